// ### hdl/mie_pkg.sv
package mie_pkg;

  localparam int PC_W        = 12;
  localparam int DATA_W      = 8;
  localparam int STACK_DEPTH = 6;

  localparam logic [7:0] ACC_ADDR   = 8'hff;
  localparam logic [7:0] PTR_ADDR   = 8'h80;
  localparam logic [7:0] SHORT_BASE = 8'h80;

  // Low opcode nibble selects the group; even nibbles are short branches.
  localparam logic [3:0] LO_CALL  = 4'h1;
  localparam logic [3:0] LO_BTST  = 4'h3;
  localparam logic [3:0] LO_SHORT = 4'h5;
  localparam logic [3:0] LO_IND   = 4'h7;
  localparam logic [3:0] LO_JP    = 4'h9;
  localparam logic [3:0] LO_BIT   = 4'hb;
  localparam logic [3:0] LO_INH   = 4'hd;
  localparam logic [3:0] LO_DIR   = 4'hf;

  localparam logic [2:0] REL_NZ = 3'h0;
  localparam logic [2:0] REL_NC = 3'h2;
  localparam logic [2:0] REL_Z  = 3'h4;
  localparam logic [2:0] REL_C  = 3'h6;

  localparam int OP_DIR_BIT = 3;
  localparam int OP_SEL_BIT = 4;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_AND = 3'h1, ALU_CP  = 3'h2, ALU_SUB = 3'h3,
    ALU_INC = 3'h4, ALU_DEC = 3'h5, ALU_CLR = 3'h6, ALU_RSV = 3'h7
  } mie_alu_e;

  localparam logic [3:0] INH_COM  = 4'h0;
  localparam logic [3:0] INH_RLC  = 4'h1;
  localparam logic [3:0] INH_SLA  = 4'h2;
  localparam logic [3:0] INH_NOP  = 4'h3;
  localparam logic [3:0] INH_RET  = 4'h4;
  localparam logic [3:0] INH_INTERRUPT_RETURN = 4'h5;
  localparam logic [3:0] INH_STOP = 4'h6;
  localparam logic [3:0] INH_WAIT = 4'h7;

  localparam logic [2:0] CYC_ALU  = 3'h4;
  localparam logic [2:0] CYC_REL  = 3'h2;
  localparam logic [2:0] CYC_BTST = 3'h5;
  localparam logic [2:0] CYC_BIT  = 3'h4;
  localparam logic [2:0] CYC_CTL  = 3'h2;
  localparam logic [2:0] CYC_JMP  = 3'h4;

  localparam logic [2:0] CNT_OP  = 3'h0;
  localparam logic [2:0] CNT_B2  = 3'h1;
  localparam logic [2:0] CNT_PTR = 3'h2;
  localparam logic [2:0] CNT_ONE = 3'h1;

  localparam logic [PC_W-1:0] LEN_ONE   = 12'h001;
  localparam logic [PC_W-1:0] LEN_TWO   = 12'h002;
  localparam logic [PC_W-1:0] LEN_THREE = 12'h003;
  localparam logic [PC_W-1:0] PC_RESET  = 12'h000;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } mie_state_e;

endpackage

// ### hdl/mie_stack.sv
`timescale 1ns/100ps
module mie_stack
  import mie_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Push and pop.
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] top_o
);

  logic [WIDTH-1:0] ent_q [DEPTH];
  logic [WIDTH-1:0] up_w  [DEPTH];
  logic [WIDTH-1:0] dn_w  [DEPTH];

  // A shift stack: a seventh push silently drops the oldest entry.
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    // Neighbours are chosen at elaboration so no index leaves the array.
    if (i == 0) begin : g_first
      assign up_w[i] = data_i;
    end else begin : g_inner
      assign up_w[i] = ent_q[i-1];
    end
    if (i == DEPTH - 1) begin : g_last
      assign dn_w[i] = '0;
    end else begin : g_below
      assign dn_w[i] = ent_q[i+1];
    end
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        ent_q[i] <= '0;
      end else if (push_i) begin // see RQ18
        ent_q[i] <= up_w[i];
      end else if (pop_i) begin
        ent_q[i] <= dn_w[i];
      end
    end
  end

  assign top_o = ent_q[0];

endmodule

// ### hdl/mie_core.sv
`timescale 1ns/100ps
// Summary of operation
// RQ1 - Add, and, compare, subtract use accumulator operand
// RQ2 - Clear/inc/dec any address; inc/dec keep carry
// RQ3 - Complement, rotate, shift: accumulator only, both flags
// RQ4 - Arithmetic ops take four cycles, update flags
// RQ5 - Indirect one byte, direct/immediate two bytes; direct clear of a non-accumulator address takes three bytes here
// RQ6 - Short branches test flags, two cycles, flags kept
// RQ7 - Short branch reaches -15 to +16
// RQ8 - Bit-test branches: three bytes, five cycles
// RQ9 - Tested bit goes to carry, zero kept
// RQ10 - Bit-test displacement reaches -126 to +129
// RQ11 - Bit set/clear: two bytes, four cycles, flagless
// RQ12 - Control ops one byte, two cycles
// RQ13 - Watchdog selected turns stop into wait
// RQ14 - Jump and call: 12-bit target, four cycles
// RQ15 - Opcode bit picks branch direction, nibble span
// RQ16 - Target is opcode nibble joined with byte
// RQ17 - Opcode bit 4 selects pointer register
// RQ18 - Return stack holds six 12-bit entries
// RQ19 - Compare sets flags, keeps accumulator
// RQ20 - Call pushes next address; returns pop it
module mie_core
  import mie_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Program memory, combinational read.
  output logic      [PC_W-1:0]   pm_addr_o,
  input  wire logic [DATA_W-1:0] pm_data_i,
  // Data space, combinational read, write on dm_we_o.
  output logic      [7:0]        dm_addr_o,
  input  wire logic [DATA_W-1:0] dm_rdata_i,
  output logic      [DATA_W-1:0] dm_wdata_o,
  output logic                   dm_we_o,
  // Power control.
  input  wire logic              wdg_sel_i,
  input  wire logic              wake_i,
  output logic                   stop_o,
  output logic                   wait_o,
  // Flags saved by interrupt entry.
  input  wire logic              saved_z_i,
  input  wire logic              saved_c_i,
  // Core state.
  output logic      [DATA_W-1:0] acc_o,
  output logic                   zero_o,
  output logic                   carry_o,
  output logic      [PC_W-1:0]   pc_o
);

  mie_state_e        state_q;
  logic [2:0]        cnt_q;
  logic [7:0]        op_q;
  logic [7:0]        b2_q;
  logic [7:0]        b3_q;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   pm_addr_q;
  logic [DATA_W-1:0] acc_q;
  logic              z_q;
  logic              c_q;
  logic [7:0]        dm_addr_q;
  logic [DATA_W-1:0] dm_wdata_q;
  logic              dm_we_q;
  logic              stop_q;
  logic              wait_q;

  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    if (!op[0]) begin
      cycles_of = CYC_REL;
    end else if (lo == LO_CALL || lo == LO_JP) begin
      cycles_of = CYC_JMP;
    end else if (lo == LO_BTST) begin
      cycles_of = CYC_BTST;
    end else if (lo == LO_BIT) begin
      cycles_of = CYC_BIT;
    end else if (lo == LO_INH && op[7:4] > INH_SLA) begin
      cycles_of = CYC_CTL;
    end else begin
      cycles_of = CYC_ALU;
    end
  endfunction

  logic [7:0]        op_w;
  logic [7:0]        b2_w;
  logic              is_rel;
  logic              is_call;
  logic              is_jp;
  logic              is_btst;
  logic              is_short;
  logic              is_ind;
  logic              is_bit;
  logic              is_inh;
  logic              is_dir;
  logic              is_imm;
  mie_alu_e          alu;
  logic [3:0]        inh;
  logic              exec_w;
  logic [DATA_W-1:0] rd_w;
  logic [DATA_W-1:0] src_w;
  logic              tbit_w;

  // The opcode is used straight from program memory in its fetch cycle.
  assign op_w     = (cnt_q == CNT_OP) ? pm_data_i : op_q;
  assign b2_w     = (cnt_q == CNT_B2) ? pm_data_i : b2_q;
  assign is_rel   = !op_w[0];
  assign is_call  = op_w[3:0] == LO_CALL;
  assign is_jp    = op_w[3:0] == LO_JP;
  assign is_btst  = op_w[3:0] == LO_BTST;
  assign is_short = op_w[3:0] == LO_SHORT;
  assign is_ind   = op_w[3:0] == LO_IND;
  assign is_bit   = op_w[3:0] == LO_BIT;
  assign is_inh   = op_w[3:0] == LO_INH;
  assign is_dir   = op_w[3:0] == LO_DIR;
  assign alu      = mie_alu_e'(op_w[7:5]);
  assign inh      = op_w[7:4];
  assign is_imm   = is_dir && op_w[OP_SEL_BIT] && !alu[2]; // see RQ1
  assign exec_w   = (state_q == ST_RUN)
                  && (cnt_q == cycles_of(op_w) - CNT_ONE); // see RQ4
  // The accumulator lives in the data space at its own address.
  assign rd_w     = (dm_addr_q == ACC_ADDR) ? acc_q : dm_rdata_i;
  assign src_w    = is_imm ? b2_q : rd_w; // see RQ1
  assign tbit_w   = rd_w[op_q[7:5]];

  logic [8:0]        res9;
  logic              wr_acc;
  logic              wr_mem;
  logic              upd_z;
  logic              upd_c;
  logic              taken;
  logic [PC_W-1:0]   next_pc;
  logic [PC_W-1:0]   stk_top;
  logic [7:0]        bmask;

  always_comb begin
    res9   = '0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    bmask  = 8'h01 << op_w[7:5];
    if (is_ind || is_dir) begin
      case (alu)
        ALU_ADD: begin
          res9   = {1'b0, acc_q} + {1'b0, src_w};
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          upd_c  = 1'b1;
        end
        ALU_AND: begin
          res9   = {1'b0, acc_q & src_w};
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          upd_c  = 1'b1;
        end
        ALU_CP: begin
          res9   = {1'b0, acc_q} - {1'b0, src_w}; // see RQ19
          upd_z  = 1'b1;
          upd_c  = 1'b1;
        end
        ALU_SUB: begin
          res9   = {1'b0, acc_q} - {1'b0, src_w};
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          upd_c  = 1'b1;
        end
        ALU_INC: begin
          res9   = {1'b0, rd_w} + 9'h001;
          wr_mem = 1'b1;
          upd_z  = 1'b1; // see RQ2
        end
        ALU_DEC: begin
          res9   = {1'b0, rd_w} - 9'h001;
          wr_mem = 1'b1;
          upd_z  = 1'b1; // see RQ2
        end
        ALU_CLR: begin
          wr_mem = 1'b1;
          // Only clearing the accumulator touches the flags.
          upd_z  = dm_addr_q == ACC_ADDR; // see RQ2
          upd_c  = dm_addr_q == ACC_ADDR;
        end
        default: begin
          res9 = '0;
        end
      endcase
    end else if (is_short) begin
      res9   = op_w[OP_SEL_BIT] ? {1'b0, rd_w} + 9'h001
                                : {1'b0, rd_w} - 9'h001;
      wr_mem = 1'b1;
      upd_z  = 1'b1; // see RQ2
    end else if (is_bit) begin
      res9   = {1'b0, op_w[OP_SEL_BIT] ? (rd_w | bmask)
                                       : (rd_w & ~bmask)}; // see RQ11
      wr_mem = 1'b1;
    end else if (is_inh) begin
      case (inh)
        INH_COM: res9 = {acc_q[7], ~acc_q}; // see RQ3
        INH_RLC: res9 = {acc_q, c_q};       // see RQ3
        INH_SLA: res9 = {acc_q, 1'b0};      // see RQ3
        default: res9 = '0;
      endcase
      wr_acc = inh <= INH_SLA;
      upd_z  = inh <= INH_SLA;
      upd_c  = inh <= INH_SLA;
    end
  end

  always_comb begin
    taken   = 1'b0;
    next_pc = pc_q + LEN_ONE; // see RQ5
    if (is_rel) begin
      case (op_w[2:0])
        REL_NZ:  taken = !z_q; // see RQ6
        REL_NC:  taken = !c_q;
        REL_Z:   taken = z_q;
        REL_C:   taken = c_q;
        default: taken = 1'b0;
      endcase
      if (taken) begin
        next_pc = op_w[OP_DIR_BIT] ? pc_q - {8'h00, op_w[7:4]}
                : pc_q + {8'h00, op_w[7:4]} + LEN_ONE; // see RQ7 RQ15
      end
    end else if (is_btst) begin
      taken   = tbit_w == op_w[OP_SEL_BIT]; // see RQ8
      next_pc = taken ? pc_q + LEN_TWO + {{4{b3_q[7]}}, b3_q}
              : pc_q + LEN_THREE; // see RQ10
    end else if (is_call || is_jp) begin
      next_pc = {op_w[7:4], b2_q}; // see RQ14 RQ16
    end else if (is_inh && (inh == INH_RET || inh == INH_INTERRUPT_RETURN)) begin
      next_pc = stk_top; // see RQ20
    end else if (is_dir && alu == ALU_CLR) begin
      next_pc = pc_q + ((b2_q == ACC_ADDR) ? LEN_TWO : LEN_THREE);
    end else if (is_dir || is_bit || (is_inh && inh == INH_SLA)) begin
      next_pc = pc_q + LEN_TWO; // see RQ5
    end
  end

  mie_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .push_i    (exec_w && is_call), // see RQ18 RQ20
    .pop_i     (exec_w && is_inh && (inh == INH_RET || inh == INH_INTERRUPT_RETURN)),
    .data_i    (pc_q + LEN_TWO),
    .top_o     (stk_top)
  );

  // Sequencing and fetch.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q   <= ST_RUN;
      cnt_q     <= CNT_OP;
      pc_q      <= PC_RESET;
      pm_addr_q <= PC_RESET;
      stop_q    <= 1'b0;
      wait_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          cnt_q     <= exec_w ? CNT_OP : cnt_q + CNT_ONE;
          pm_addr_q <= exec_w ? next_pc : pm_addr_q + LEN_ONE;
          if (exec_w) begin
            pc_q <= next_pc;
          end
          if (exec_w && is_inh && inh == INH_STOP) begin
            state_q <= ST_HALT;
            stop_q  <= !wdg_sel_i; // see RQ13
            wait_q  <= wdg_sel_i;
          end else if (exec_w && is_inh && inh == INH_WAIT) begin
            state_q <= ST_HALT;
            wait_q  <= 1'b1;
          end
        end
        ST_HALT: begin
          if (wake_i) begin
            state_q <= ST_RUN;
            stop_q  <= 1'b0;
            wait_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Instruction bytes.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_q <= '0;
      b2_q <= '0;
      b3_q <= '0;
    end else if (state_q == ST_RUN) begin
      if (cnt_q == CNT_OP) begin
        op_q <= pm_data_i;
      end
      if (cnt_q == CNT_B2) begin
        b2_q <= pm_data_i;
      end
      if (cnt_q == CNT_PTR) begin
        b3_q <= pm_data_i;
      end
    end
  end

  // Data space addressing; the write lands one cycle after execution.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dm_addr_q  <= PTR_ADDR;
      dm_we_q    <= 1'b0;
      dm_wdata_q <= '0;
    end else begin
      dm_we_q    <= exec_w && wr_mem && dm_addr_q != ACC_ADDR;
      dm_wdata_q <= res9[7:0];
      if (state_q == ST_RUN && cnt_q == CNT_B2) begin
        if (is_ind) begin
          dm_addr_q <= PTR_ADDR + {7'h00, op_w[OP_SEL_BIT]}; // see RQ17
        end else if (is_short) begin
          dm_addr_q <= SHORT_BASE + {6'h00, op_w[7:6]};
        end else if (is_dir || is_bit || is_btst) begin
          dm_addr_q <= b2_w; // see RQ2
        end
      end else if (state_q == ST_RUN && cnt_q == CNT_PTR && is_ind) begin
        dm_addr_q <= rd_w;
      end
    end
  end

  // Accumulator and flags.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_q <= '0;
      z_q   <= 1'b0;
      c_q   <= 1'b0;
    end else if (exec_w) begin
      if (wr_acc || (wr_mem && dm_addr_q == ACC_ADDR)) begin
        acc_q <= res9[7:0];
      end
      if (upd_z) begin
        z_q <= res9[7:0] == 8'h00;
      end
      if (upd_c) begin
        c_q <= (alu == ALU_AND && !is_inh) ? 1'b0 : res9[8];
      end
      if (is_btst) begin
        c_q <= tbit_w; // see RQ9
      end
      if (is_inh && inh == INH_INTERRUPT_RETURN) begin
        z_q <= saved_z_i; // see RQ12
        c_q <= saved_c_i;
      end
    end
  end

  assign pm_addr_o  = pm_addr_q;
  assign dm_addr_o  = dm_addr_q;
  assign dm_wdata_o = dm_wdata_q;
  assign dm_we_o    = dm_we_q;
  assign stop_o     = stop_q;
  assign wait_o     = wait_q;
  assign acc_o      = acc_q;
  assign zero_o     = z_q;
  assign carry_o    = c_q;
  assign pc_o       = pc_q;

  alu_four_cyc_a: assert property (@(posedge clk_i) // see RQ4
    disable iff (sys_rst_i)
    exec_w && (is_ind || is_dir) |-> cnt_q == CYC_ALU - CNT_ONE)
    else $error("Arithmetic op did not end in its fourth cycle.");

  rel_flags_kept_a: assert property (@(posedge clk_i) // see RQ6
    disable iff (sys_rst_i)
    exec_w && is_rel |=> $stable(z_q) && $stable(c_q) && cnt_q == CNT_OP)
    else $error("Short branch altered a flag.");

  btst_carry_a: assert property (@(posedge clk_i) // see RQ9
    disable iff (sys_rst_i)
    exec_w && is_btst |=> c_q == $past(tbit_w) && $stable(z_q))
    else $error("Tested bit not copied into carry.");

  stop_as_wait_a: assert property (@(posedge clk_i) // see RQ13
    disable iff (sys_rst_i)
    exec_w && is_inh && inh == INH_STOP && wdg_sel_i |=> wait_o && !stop_o)
    else $error("Stop executed while watchdog selected.");

  jump_target_a: assert property (@(posedge clk_i) // see RQ16
    disable iff (sys_rst_i)
    exec_w && is_jp |=> pc_q == {$past(op_q[7:4]), $past(b2_q)})
    else $error("Jump target not formed from opcode and byte.");

  cmp_keeps_acc_a: assert property (@(posedge clk_i) // see RQ19
    disable iff (sys_rst_i)
    exec_w && (is_ind || is_dir) && alu == ALU_CP |=> $stable(acc_q))
    else $error("Compare changed the accumulator.");

  incdec_carry_a: assert property (@(posedge clk_i) // see RQ2
    disable iff (sys_rst_i)
    exec_w && is_short |=> $stable(c_q) && dm_we_o
      && dm_addr_o[7:2] == SHORT_BASE[7:2])
    else $error("Short increment or decrement touched carry.");

  call_return_a: assert property (@(posedge clk_i) // see RQ20
    disable iff (sys_rst_i)
    exec_w && is_call |=> stk_top == $past(pc_q) + LEN_TWO)
    else $error("Call did not push the following address.");

  bit_op_len_a: assert property (@(posedge clk_i) // see RQ11
    disable iff (sys_rst_i)
    exec_w && is_bit |-> cnt_q == CYC_BIT - CNT_ONE ##1
      pc_q == $past(pc_q) + LEN_TWO && $stable(z_q) && $stable(c_q))
    else $error("Bit set or clear broke length, timing or flags.");

endmodule

// ### tb/mie_mem_model.sv
`timescale 1ns/100ps
module mie_mem_model
  import mie_pkg::*;
(
  // Clock.
  input  wire logic              clk_i,
  // Program memory port.
  input  wire logic [PC_W-1:0]   pm_addr_i,
  output logic      [DATA_W-1:0] pm_data_o,
  // Data space port.
  input  wire logic [7:0]        dm_addr_i,
  output logic      [DATA_W-1:0] dm_rdata_o,
  input  wire logic [DATA_W-1:0] dm_wdata_i,
  input  wire logic              dm_we_i
);
  logic [DATA_W-1:0] pm [0:4095];
  logic [DATA_W-1:0] dm [0:255];

  // Both reads answer in the same cycle, since the core allows no latency.
  assign pm_data_o  = pm[pm_addr_i];
  assign dm_rdata_o = dm[dm_addr_i];

  // The bench also preloads this array, so a plain process is used here.
  always @(posedge clk_i) begin
    if (dm_we_i === 1'b1) begin
      dm[dm_addr_i] <= dm_wdata_i;
    end
  end
endmodule

// ### tb/mie_core_tb.sv
`timescale 1ns/100ps
module mie_core_tb;
  logic        clk_i;
  logic        sys_rst_i;
  logic        wdg_sel_i;
  logic        wake_i;
  logic        saved_z_i;
  logic        saved_c_i;
  logic [11:0] pm_addr_o;
  logic [11:0] pc_o;
  logic [7:0]  pm_data_i;
  logic [7:0]  dm_addr_o;
  logic [7:0]  dm_rdata_i;
  logic [7:0]  dm_wdata_o;
  logic [7:0]  acc_o;
  logic        dm_we_o;
  logic        stop_o;
  logic        wait_o;
  logic        zero_o;
  logic        carry_o;
  int          bad_count;
  int          checked;

  mie_core u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .dm_addr_o(dm_addr_o), .dm_rdata_i(dm_rdata_i),
    .dm_wdata_o(dm_wdata_o), .dm_we_o(dm_we_o), .wdg_sel_i(wdg_sel_i),
    .wake_i(wake_i), .stop_o(stop_o), .wait_o(wait_o),
    .saved_z_i(saved_z_i), .saved_c_i(saved_c_i), .acc_o(acc_o),
    .zero_o(zero_o), .carry_o(carry_o), .pc_o(pc_o)
  );

  mie_mem_model u_mem (
    .clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
    .dm_addr_i(dm_addr_o), .dm_rdata_o(dm_rdata_i),
    .dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Unwritten program space holds no-operations so a stray fetch is harmless.
  task automatic prep;
    sys_rst_i = 1'b1;
    for (int i = 0; i < 4096; i++) u_mem.pm[i] = 8'h3d;
    for (int i = 0; i < 256; i++) u_mem.dm[i] = 8'h00;
  endtask

  task automatic ld(input logic [11:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_mem.pm[a + 12'(i)] = b[i];
  endtask

  task automatic run;
    repeat (10) @(posedge clk_i);
    #1;
    check({pc_o, acc_o, zero_o, carry_o, dm_we_o, stop_o, wait_o}, 32'h0);
    sys_rst_i = 1'b0;
  endtask

  // Cycle counts are taken between successive program counter changes, so
  // any fixed lag of the counter behind the fetch cancels out.
  task automatic step(input logic [11:0] a, input int cyc,
                      input logic [7:0] ea, input logic [1:0] fl);
    int n;
    n = 0;
    while (n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
      if (pc_o === a) break;
    end
    check(pc_o, a);
    if (pc_o !== a) complete_run();
    if (cyc != 0) check(n, cyc);
    check(acc_o, ea);
    check({zero_o, carry_o}, fl);
  endtask

  task automatic hold_until(input logic stp, input logic v);
    int n;
    n = 0;
    while (n < 40 && (stp ? stop_o : wait_o) !== v) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(stp ? stop_o : wait_o, v);
    if ((stp ? stop_o : wait_o) !== v) complete_run();
  endtask

  task automatic alu_case;
    prep();
    ld(12'h000, '{8'h3d, 8'h1f, 8'h9c, 8'h0f, 8'h20, 8'h1f, 8'h40, 8'h5f,
                  8'h11, 8'h3f, 8'h01, 8'h7f, 8'h02, 8'h0d, 8'h1d, 8'h2d,
                  8'h00});
    u_mem.dm[8'h20] = 8'h35;
    run();
    step(12'h001, 0, 8'h00, 2'b00);
    step(12'h003, 4, 8'h9c, 2'b00);
    step(12'h005, 4, 8'hd1, 2'b00);
    step(12'h007, 4, 8'h11, 2'b01);
    step(12'h009, 4, 8'h11, 2'b10);
    step(12'h00b, 4, 8'h01, 2'b00);
    step(12'h00d, 4, 8'hff, 2'b01);
    step(12'h00e, 4, 8'h00, 2'b11);
    step(12'h00f, 4, 8'h01, 2'b00);
    step(12'h011, 4, 8'h02, 2'b00);
  endtask

  task automatic data_case;
    prep();
    ld(12'h000, '{8'h1f, 8'hff, 8'h1f, 8'h01, 8'h87, 8'hb7, 8'h95, 8'hcf,
                  8'h50, 8'h00, 8'h7b, 8'h50, 8'h4b, 8'h82, 8'haf, 8'h30,
                  8'hcf, 8'hff});
    u_mem.dm[8'hff] = 8'h5a;
    u_mem.dm[8'h80] = 8'h30;
    u_mem.dm[8'h81] = 8'h40;
    u_mem.dm[8'h30] = 8'hff;
    u_mem.dm[8'h82] = 8'h05;
    u_mem.dm[8'h50] = 8'ha5;
    run();
    step(12'h002, 0, 8'hff, 2'b00);
    step(12'h004, 4, 8'h00, 2'b11);
    step(12'h005, 4, 8'h00, 2'b11);
    step(12'h006, 4, 8'h00, 2'b01);
    step(12'h007, 4, 8'h00, 2'b01);
    step(12'h00a, 4, 8'h00, 2'b01);
    step(12'h00c, 4, 8'h00, 2'b01);
    step(12'h00e, 4, 8'h00, 2'b01);
    step(12'h010, 4, 8'h00, 2'b01);
    step(12'h012, 4, 8'h00, 2'b10);
    repeat (4) @(posedge clk_i);
    #1;
    check(u_mem.dm[8'hff], 8'h5a);
    check(u_mem.dm[8'h30], 8'hff);
    check(u_mem.dm[8'h40], 8'hff);
    check(u_mem.dm[8'h82], 8'h02);
    check(u_mem.dm[8'h50], 8'h08);
    check({u_mem.dm[8'h80], u_mem.dm[8'h81]}, 16'h3040);
  endtask

  task automatic branch_case;
    prep();
    ld(12'h000, '{8'h3d, 8'hf0, 8'h3d, 8'h53, 8'h60, 8'h7f});
    ld(12'h009, '{8'h06, 8'h1f, 8'h00, 8'h24});
    ld(12'h00f, '{8'h7f, 8'h01, 8'hfc, 8'hfa, 8'h26});
    ld(12'h084, '{8'h43, 8'h60, 8'h00, 8'h03, 8'h60, 8'h80});
    u_mem.dm[8'h60] = 8'h04;
    run();
    step(12'h001, 0, 8'h00, 2'b00);
    step(12'h011, 2, 8'h00, 2'b00);
    step(12'h012, 2, 8'h00, 2'b00);
    step(12'h003, 2, 8'h00, 2'b00);
    step(12'h084, 5, 8'h00, 2'b01);
    step(12'h087, 5, 8'h00, 2'b01);
    step(12'h009, 5, 8'h00, 2'b00);
    step(12'h00a, 2, 8'h00, 2'b00);
    step(12'h00c, 4, 8'h00, 2'b10);
    step(12'h00f, 2, 8'h00, 2'b10);
    step(12'h011, 4, 8'hff, 2'b01);
    step(12'h012, 2, 8'hff, 2'b01);
    step(12'h013, 2, 8'hff, 2'b01);
    step(12'h016, 2, 8'hff, 2'b01);
  endtask

  task automatic flow_case;
    prep();
    ld(12'h000, '{8'h3d, 8'h21, 8'h34, 8'h39, 8'hab});
    ld(12'h234, '{8'h4d});
    ld(12'h3ab, '{8'h51, 8'h00, 8'h71, 8'h00, 8'h6d, 8'h6d});
    ld(12'h500, '{8'h61, 8'h00, 8'h4d});
    ld(12'h600, '{8'h4d});
    ld(12'h700, '{8'h5d});
    wdg_sel_i = 1'b1;
    run();
    step(12'h001, 0, 8'h00, 2'b00);
    step(12'h234, 4, 8'h00, 2'b00);
    step(12'h003, 2, 8'h00, 2'b00);
    step(12'h3ab, 4, 8'h00, 2'b00);
    step(12'h500, 4, 8'h00, 2'b00);
    step(12'h600, 4, 8'h00, 2'b00);
    step(12'h502, 2, 8'h00, 2'b00);
    step(12'h3ad, 2, 8'h00, 2'b00);
    step(12'h700, 4, 8'h00, 2'b00);
    step(12'h3af, 2, 8'h00, 2'b11);
    hold_until(1'b0, 1'b1);
    check(stop_o, 1'b0);
    wdg_sel_i = 1'b0;
    wake_i = 1'b1;
    hold_until(1'b0, 1'b0);
    wake_i = 1'b0;
    hold_until(1'b1, 1'b1);
    check(wait_o, 1'b0);
    wake_i = 1'b1;
    hold_until(1'b1, 1'b0);
    wake_i = 1'b0;
  endtask

  initial begin
    sys_rst_i = 1'b1;
    wdg_sel_i = 1'b0;
    wake_i = 1'b0;
    saved_z_i = 1'b1;
    saved_c_i = 1'b1;
    bad_count = 0;
    checked = 0;
    @(posedge clk_i);
    #1;
    alu_case();
    data_case();
    branch_case();
    flow_case();
    complete_run();
  end
endmodule
